// ==== hdl/lrc_pkg.sv ====
package lrc_pkg;
  localparam int LRC_ADDR_W = 8;
  localparam int LRC_DATA_W = 8;
  localparam int LRC_TAP_W = 4;
  localparam int LRC_LADDER_W = 32;
  // Register index of the control register.
  localparam logic [7:0] LRC_REFERENCE_CONTROL_ADDR = 8'h9f;
  localparam logic [7:0] LRC_REFERENCE_CONTROL_RST = 8'h00;
  localparam int LRC_POWER_BIT = 7;
  localparam int LRC_OUTPUT_BIT = 6;
  localparam int LRC_RANGE_BIT = 5;
  localparam int LRC_UNUSED_BIT = 4;
  localparam int LRC_TAP_LSB = 0;
  localparam logic [7:0] LRC_WRITE_MASK = 8'hef;
  // Ladder geometry: low range uses tap/24, high range starts at 8/32 of supply.
  localparam int LRC_LOW_DEN = 24;
  localparam int LRC_HIGH_DEN = 32;
  localparam int LRC_HIGH_BASE = 8;
endpackage

// ==== hdl/lrc_ladder_reference_control.sv ====
`timescale 1ns/100ps
module lrc_ladder_reference_control (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [lrc_pkg::LRC_ADDR_W-1:0] reg_addr,
  input wire logic [lrc_pkg::LRC_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [lrc_pkg::LRC_DATA_W-1:0] reg_rdata_r,
  // Analog ladder controls.
  output logic ladder_power_r,
  output logic level_pin_output_enable_r,
  output logic [lrc_pkg::LRC_LADDER_W-1:0] tap_onehot_r,
  output logic [lrc_pkg::LRC_TAP_W:0] level_num_r,
  output logic [lrc_pkg::LRC_TAP_W+1:0] level_den_r
);
  import lrc_pkg::*;

  logic [LRC_DATA_W-1:0] reference_control_r;
  logic reg_hit;
  logic range_low;
  logic [LRC_TAP_W-1:0] tap_select;
  logic [LRC_TAP_W:0] ladder_tap;
  logic ctrl_write;

  assign reg_hit = (reg_addr == LRC_REFERENCE_CONTROL_ADDR);
  assign ctrl_write = reg_write && reg_hit;
  assign range_low = reference_control_r[LRC_RANGE_BIT];
  assign tap_select = reference_control_r[LRC_TAP_LSB +: LRC_TAP_W];

  // Ladder tap index out of 32 for high range, out of 24 for low range.
  function automatic logic [LRC_TAP_W:0] lrc_tap_index(input logic low,
                                                       input logic [LRC_TAP_W-1:0] sel);
    if (low) begin
      lrc_tap_index = {1'b0, sel};
    end else begin
      lrc_tap_index = 5'(LRC_HIGH_BASE) + {1'b0, sel};
    end
  endfunction

  assign ladder_tap = lrc_tap_index(range_low, tap_select);

  // Control register; bit 4 is never stored.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reference_control_r <= LRC_REFERENCE_CONTROL_RST;
    end else if (reg_write && reg_hit) begin
      reference_control_r <= reg_wdata & LRC_WRITE_MASK;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata_r <= '0;
    end else if (reg_read && reg_hit) begin
      reg_rdata_r <= reference_control_r;
    end else begin
      reg_rdata_r <= '0;
    end
  end

  // Power and pin switch follow the stored bits one cycle after the register.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ladder_power_r <= 1'b0;
      level_pin_output_enable_r <= 1'b0;
    end else begin
      ladder_power_r <= reference_control_r[LRC_POWER_BIT];
      level_pin_output_enable_r <= reference_control_r[LRC_OUTPUT_BIT];
    end
  end

  // Powered down means no tap is selected, so the string draws no current.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tap_onehot_r <= '0;
    end else if (reference_control_r[LRC_POWER_BIT]) begin
      tap_onehot_r <= LRC_LADDER_W'(1) << ladder_tap;
    end else begin
      tap_onehot_r <= '0;
    end
  end

  // The level is handed over as a fraction, so the analog side needs no divider.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_num_r <= '0;
      level_den_r <= '0;
    end else begin
      level_num_r <= ladder_tap;
      level_den_r <= range_low ? 6'(LRC_LOW_DEN) : 6'(LRC_HIGH_DEN);
    end
  end

  // Settling after a tap or range change is left to software; there is no busy flag.

  // Register port checks.
  unused_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
    reference_control_r[LRC_UNUSED_BIT] == 1'b0)
    else $error("unused control bit became set");

  reset_clear_a: assert property (@(posedge clk)
    !reset_n |=> (reference_control_r == LRC_REFERENCE_CONTROL_RST && reg_rdata_r == '0
      && !ladder_power_r && !level_pin_output_enable_r && tap_onehot_r == '0))
    else $error("reset left control state set");

  write_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_write |=> (reference_control_r == ($past(reg_wdata) & LRC_WRITE_MASK)))
    else $error("control write not stored");

  foreign_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_write && !reg_hit) |=> $stable(reference_control_r))
    else $error("write to another address changed the control register");

  read_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_read && !reg_write) |=> $stable(reference_control_r))
    else $error("read changed the control register");

  read_back_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_read && reg_hit) |=> (reg_rdata_r == $past(reference_control_r)))
    else $error("control read data wrong");

  read_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(reg_read && reg_hit) |=> (reg_rdata_r == '0))
    else $error("read data not zero outside a read");

  fresh_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_write ##1 (reg_read && reg_hit)
      |=> (reg_rdata_r == ($past(reg_wdata, 2) & LRC_WRITE_MASK)))
    else $error("read right after a write missed the new value");

  // Ladder drive checks.
  power_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_write |=> ##1 (ladder_power_r == $past(reg_wdata[LRC_POWER_BIT], 2)))
    else $error("ladder power does not follow bit 7");

  power_down_a: assert property (@(posedge clk) disable iff (!reset_n)
    !ladder_power_r
      |-> ($past(reference_control_r[LRC_POWER_BIT]) == 1'b0 && tap_onehot_r == '0))
    else $error("ladder selects a tap while powered down");

  power_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(ladder_power_r) |-> $past(ctrl_write, 2))
    else $error("ladder power changed without a control write");

  pin_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_write |=> ##1
      (level_pin_output_enable_r == $past(reg_wdata[LRC_OUTPUT_BIT], 2)))
    else $error("pin enable does not follow bit 6");

  pin_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(level_pin_output_enable_r) |-> $past(ctrl_write, 2))
    else $error("pin enable changed without a control write");

  tap_onehot_a: assert property (@(posedge clk) disable iff (!reset_n)
    ladder_power_r |-> $onehot(tap_onehot_r))
    else $error("tap select not one-hot while powered");

  tap_position_a: assert property (@(posedge clk) disable iff (!reset_n)
    ladder_power_r |-> tap_onehot_r[level_num_r])
    else $error("selected tap does not match the level numerator");

  tap_top_a: assert property (@(posedge clk) disable iff (!reset_n)
    (tap_onehot_r >> LRC_LOW_DEN) == '0)
    else $error("tap above the ladder top selected");

  // Level fraction checks.
  // The reset_n term keeps the edge that releases reset from starting a check.
  low_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_n && range_low)
      |=> (level_den_r == 6'(LRC_LOW_DEN) && level_num_r == {1'b0, $past(tap_select)}))
    else $error("low range level wrong");

  high_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_n && !range_low) |=> (level_den_r == 6'(LRC_HIGH_DEN)
      && level_num_r == 5'(LRC_HIGH_BASE) + {1'b0, $past(tap_select)}))
    else $error("high range level wrong");

  den_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_write |=> ##1 (level_den_r == ($past(reg_wdata[LRC_RANGE_BIT], 2)
      ? 6'(LRC_LOW_DEN) : 6'(LRC_HIGH_DEN))))
    else $error("level scale does not follow the range bit");

  low_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    (level_den_r == 6'(LRC_LOW_DEN))
      |-> (level_num_r <= {1'b0, {LRC_TAP_W{1'b1}}}))
    else $error("low range level outside its sixteen steps");

  high_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    (level_den_r == 6'(LRC_HIGH_DEN)) |-> (level_num_r >= 5'(LRC_HIGH_BASE)
      && level_num_r <= 5'(LRC_HIGH_BASE) + {1'b0, {LRC_TAP_W{1'b1}}}))
    else $error("high range level outside its sixteen steps");

endmodule // lrc_ladder_reference_control

// ==== test/lrc_ladder_reference_control_bench.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module lrc_ladder_reference_control_bench;
  import lrc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata_r, rd_val;
  logic ladder_power_r, level_pin_output_enable_r;
  logic [31:0] tap_onehot_r;
  logic [4:0] level_num_r;
  logic [5:0] level_den_r;
  int err_total = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  lrc_ladder_reference_control dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_r(reg_rdata_r), .ladder_power_r(ladder_power_r),
    .level_pin_output_enable_r(level_pin_output_enable_r), .tap_onehot_r(tap_onehot_r),
    .level_num_r(level_num_r), .level_den_r(level_den_r));
  // Returns once the ladder outputs have followed the write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    // Software waits for the new level before it relies on the outputs.
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata_r;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("power", 1'b0, ladder_power_r)
    `CHK("pin", 1'b0, level_pin_output_enable_r)
    `CHK("onehot", 32'h0, tap_onehot_r)
    `CHK("den", 6'h20, level_den_r)
    rd(8'h9f, rd_val);
    `CHK("reset value", LRC_REFERENCE_CONTROL_RST, rd_val)
    // Bit 4 is set on every write so that each step also proves it is dropped.
    for (int r = 0; r < 2; r++) begin
      for (int t = 0; t < 16; t++) begin
        wr(8'h9f, {3'b110 | 3'(r), 1'b1, 4'(t)});
        `CHK("power", 1'b1, ladder_power_r)
        `CHK("pin", 1'b1, level_pin_output_enable_r)
        `CHK("num", 5'(r ? t : 8 + t), level_num_r)
        `CHK("den", 6'(r ? 24 : 32), level_den_r)
        `CHK("onehot", 32'h1 << (r ? t : 8 + t), tap_onehot_r)
        rd(8'h9f, rd_val);
        `CHK("readback", {3'b110 | 3'(r), 1'b0, 4'(t)}, rd_val)
      end
    end
    @(posedge clk);
    #1;
    `CHK("idle rdata", 8'h00, reg_rdata_r)
    // A read in the cycle right after a write must already see the new value.
    @(posedge clk);
    reg_addr <= 8'h9f;
    reg_wdata <= 8'h35;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK("fresh read", 8'h25, reg_rdata_r)
    wr(8'h9f, 8'h4a);
    `CHK("power", 1'b0, ladder_power_r)
    `CHK("pin", 1'b1, level_pin_output_enable_r)
    `CHK("onehot", 32'h0, tap_onehot_r)
    wr(8'h9f, 8'h8a);
    `CHK("pin", 1'b0, level_pin_output_enable_r)
    wr(8'h9e, 8'hff);
    `CHK("power", 1'b1, ladder_power_r)
    rd(8'h9f, rd_val);
    `CHK("kept", 8'h8a, rd_val)
    rd(8'h9e, rd_val);
    `CHK("unmapped", 8'h00, rd_val)
    // A second reset in mid-run must clear the live configuration again.
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("reset power", 1'b0, ladder_power_r)
    `CHK("reset onehot", 32'h0, tap_onehot_r)
    rd(8'h9f, rd_val);
    `CHK("reset again", LRC_REFERENCE_CONTROL_RST, rd_val)
    give_verdict();
  end
endmodule // lrc_ladder_reference_control_bench
